// File: logic/ces_pkg.sv
// Purpose: Shared constants and types of the controller error supervisor
// Assumes: APB slave with 32-bit data, byte offsets below
// Notes: Codes 43 and above are software-clearable diagnostic errors
package ces_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_CHK_ADDR = 8'h0c;
  localparam logic [7:0] OFS_CODE = 8'h10;
  localparam logic [7:0] OFS_FAULT_A = 8'h14;
  localparam logic [7:0] OFS_FAULT_B = 8'h18;
  // Control register write-one pulse bits
  localparam int CTRL_RUN = 0;
  localparam int CTRL_CHECK = 1;
  localparam int CTRL_CLEAR = 2;
  localparam int CTRL_REWRITE = 3;
  localparam int CTRL_REFUSED_CLR = 4;
  // Configuration bits
  localparam int CFG_DUP_OK = 0;
  localparam int CFG_HALT_OP = 1;
  localparam logic [1:0] CFG_RESET = 2'h2;
  // Status fields
  localparam int ST_STATE_LSB = 0;
  localparam int ST_SYN_LSB = 2;
  localparam int ST_LED = 5;
  localparam int ST_HALT = 6;
  localparam int ST_REFUSED = 7;
  localparam int ST_RPT_LSB = 8;
  localparam logic [7:0] CLEARABLE_MIN = 8'h2b;
  localparam logic [7:0] CODE_NONE = 8'h00;

  typedef enum logic [2:0] {
    SYN_NONE = 3'b000,
    SYN_E1 = 3'b001,
    SYN_E2 = 3'b010,
    SYN_E3 = 3'b011,
    SYN_E4 = 3'b100,
    SYN_E5 = 3'b101
  } ces_syn_type;

  typedef enum logic [1:0] {
    ST_EDIT = 2'b00,
    ST_CHECK = 2'b01,
    ST_RUN = 2'b10,
    ST_HOLD = 2'b11
  } ces_state_type;

  typedef enum logic [1:0] {
    CK_RUN = 2'b00,
    CK_TOOL = 2'b01,
    CK_REWRITE = 2'b10
  } ces_ckp_type;

  // Findings of the program checker for one pass
  typedef struct packed {
    logic general;
    logic relay_dup;
    logic tc_dup;
    logic pair;
    logic param;
    logic area;
    logic [15:0] addr;
  } ces_chk_type;

  // One self-diagnostic event
  typedef struct packed {
    logic op_err;
    logic [7:0] code;
    logic [31:0] addr;
  } ces_diag_type;
endpackage

// File: logic/ces_supervisor.sv
// Purpose: Error supervision of a controller CPU: indicator, run gating,
//   program check results, diagnostic code store and clearing
// Assumes: Checker, diagnostics and power monitor run on pclk
// Notes: Mode selector and init switch are pins and are synchronised
//
// What this block does
// RULE1: Indicator lit while any error pending
// RULE2: Run selection starts a full program check
// RULE3: Pending check error blocks execution
// RULE4: Remote run refused while check error pending
// RULE5: Edit mode clears check error and indicator
// RULE6: Tool check in edit reports code and address
// RULE7: Diagnostic halt depends on code and configuration
// RULE8: Diagnostic code stored in code register
// RULE9: Operation error address kept in two words
// RULE10: Software clear only for codes 43 and up
// RULE11: Init switch clears error and all memory
// RULE12: Power cycle in edit clears, erases volatile memory
// RULE13: Fault set instruction can clear the error
// RULE14: General fault is E1 and stops
// RULE15: Duplicate coil or timer number is E2
// RULE16: Duplicate-output enable hides relay case only
// RULE17: Missing pair member is E3
// RULE18: Setting conflict is E4
// RULE19: Wrong program area is E5
// RULE20: Faulty online rewrite discarded, execution continues
// RULE21: Errors stay latched until a clearing event
//
// The APB register port and the register addresses were decided locally.
module ces_supervisor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ces_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mode_run_pin,
  input wire logic init_switch_pin,
  input wire logic power_restart,
  input wire logic diag_valid,
  input wire ces_pkg::ces_diag_type diag,
  input wire logic diag_set_valid,
  input wire logic [7:0] diag_set_code,
  input wire logic chk_done,
  input wire ces_pkg::ces_chk_type chk_res,
  output logic err_led_q,
  output logic exec_run_q,
  output logic diag_halt_q,
  output logic chk_start_q,
  output logic rewrite_commit_q,
  output logic rewrite_discard_q,
  output logic mem_clear_all_q,
  output logic mem_clear_volatile_q
);
  import ces_pkg::*;

  logic [2:0] run_s_q;
  logic [2:0] init_s_q;
  logic run_f_q;
  logic run_p_q;
  logic init_f_q;
  logic init_p_q;
  logic run_rise;
  logic run_fall;
  logic init_rise;
  logic pwr_edit;
  logic acc;
  logic wr;
  logic wr_ctrl;
  logic req_run;
  logic req_check;
  logic req_clear;
  logic req_rewrite;
  logic req_ref_clr;
  logic [1:0] cfg_q;
  ces_state_type st_q;
  ces_ckp_type ck_q;
  ces_syn_type syn_q;
  ces_syn_type syn_now;
  ces_syn_type rpt_code_q;
  logic [15:0] rpt_addr_q;
  logic refused_q;
  logic [7:0] diag_code_q;
  logic [15:0] fault_a_q;
  logic [15:0] fault_b_q;
  logic diag_clr;
  logic [31:0] rd_d;
  logic hit_d;

  // Three-stage synchronisers; a level counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_s_q <= 3'h0;
      init_s_q <= 3'h0;
      run_f_q <= 1'b0;
      init_f_q <= 1'b0;
      run_p_q <= 1'b0;
      init_p_q <= 1'b0;
    end else begin
      run_s_q <= {run_s_q[1:0], mode_run_pin};
      init_s_q <= {init_s_q[1:0], init_switch_pin};
      if (run_s_q[1] == run_s_q[2]) begin
        run_f_q <= run_s_q[2];
      end
      if (init_s_q[1] == init_s_q[2]) begin
        init_f_q <= init_s_q[2];
      end
      run_p_q <= run_f_q;
      init_p_q <= init_f_q;
    end
  end

  assign run_rise = run_f_q & ~run_p_q;
  assign run_fall = ~run_f_q & run_p_q;
  assign init_rise = init_f_q & ~init_p_q;
  assign pwr_edit = power_restart & ~run_f_q;

  // APB: data prepared in the setup cycle, answered with no wait state
  assign acc = psel & penable & pready;
  assign wr = acc & pwrite;
  assign wr_ctrl = wr & (paddr == OFS_CTRL);
  assign req_run = wr_ctrl & pwdata[CTRL_RUN];
  assign req_check = wr_ctrl & pwdata[CTRL_CHECK];
  assign req_clear = wr_ctrl & pwdata[CTRL_CLEAR];
  assign req_rewrite = wr_ctrl & pwdata[CTRL_REWRITE];
  assign req_ref_clr = wr_ctrl & pwdata[CTRL_REFUSED_CLR];

  always_comb begin
    rd_d = 32'h0;
    hit_d = 1'b1;
    unique case (paddr)
      OFS_CTRL: rd_d = 32'h0;
      OFS_CFG: rd_d = {30'h0, cfg_q};
      OFS_STATUS: begin
        rd_d[ST_STATE_LSB +: 2] = st_q;
        rd_d[ST_SYN_LSB +: 3] = syn_q;
        rd_d[ST_LED] = err_led_q;
        rd_d[ST_HALT] = diag_halt_q;
        rd_d[ST_REFUSED] = refused_q;
        rd_d[ST_RPT_LSB +: 3] = rpt_code_q;
      end
      OFS_CHK_ADDR: rd_d = {16'h0, rpt_addr_q};
      OFS_CODE: rd_d = {24'h0, diag_code_q};
      OFS_FAULT_A: rd_d = {16'h0, fault_a_q};
      OFS_FAULT_B: rd_d = {16'h0, fault_b_q};
      default: hit_d = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit_d;
      if (psel & ~penable & ~pwrite) begin
        prdata <= rd_d;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= CFG_RESET;
    end else if (wr && paddr == OFS_CFG) begin
      cfg_q <= pwdata[1:0];
    end
  end

  // Checker findings to one code; the lower code has priority
  always_comb begin
    syn_now = SYN_NONE;
    if (chk_res.general) begin
      syn_now = SYN_E1; // RULE14
    end else if ((chk_res.relay_dup & ~cfg_q[CFG_DUP_OK]) | chk_res.tc_dup) begin
      syn_now = SYN_E2; // RULE15 RULE16
    end else if (chk_res.pair) begin
      syn_now = SYN_E3; // RULE17
    end else if (chk_res.param) begin
      syn_now = SYN_E4; // RULE18
    end else if (chk_res.area) begin
      syn_now = SYN_E5; // RULE19
    end
  end

  // Mode sequencing; every run entry passes the program check
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_EDIT;
      ck_q <= CK_RUN;
      chk_start_q <= 1'b0;
      rewrite_commit_q <= 1'b0;
      rewrite_discard_q <= 1'b0;
    end else begin
      chk_start_q <= 1'b0;
      rewrite_commit_q <= 1'b0;
      rewrite_discard_q <= 1'b0;
      unique case (st_q)
        ST_EDIT: begin
          if (run_rise || req_run) begin
            st_q <= ST_CHECK; // RULE2
            ck_q <= CK_RUN;
            chk_start_q <= 1'b1;
          end else if (req_check) begin
            st_q <= ST_CHECK; // RULE6
            ck_q <= CK_TOOL;
            chk_start_q <= 1'b1;
          end
        end
        ST_CHECK: begin
          if (run_fall && ck_q != CK_TOOL) begin
            st_q <= ST_EDIT;
          end else if (chk_done) begin
            unique case (ck_q)
              CK_TOOL: st_q <= ST_EDIT;
              CK_REWRITE: begin
                st_q <= ST_RUN; // RULE20
                rewrite_commit_q <= (syn_now == SYN_NONE);
                rewrite_discard_q <= (syn_now != SYN_NONE);
              end
              default: st_q <= (syn_now == SYN_NONE) ? ST_RUN : ST_HOLD; // RULE3
            endcase
          end
        end
        ST_RUN: begin
          if (run_fall) begin
            st_q <= ST_EDIT;
          end else if (req_rewrite) begin
            st_q <= ST_CHECK;
            ck_q <= CK_REWRITE;
            chk_start_q <= 1'b1;
          end
        end
        ST_HOLD: begin
          if (run_fall) begin
            st_q <= ST_EDIT; // RULE5
          end
        end
      endcase
    end
  end

  // Pending check error, latched until edit mode or a clearing event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      syn_q <= SYN_NONE;
    end else if (st_q == ST_CHECK && ck_q == CK_RUN && chk_done && !run_fall) begin
      syn_q <= syn_now;
    end else if (run_fall || init_rise || pwr_edit) begin
      syn_q <= SYN_NONE; // RULE5 RULE11 RULE12 RULE21
    end
  end

  // Tool check report and refused remote runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rpt_code_q <= SYN_NONE;
      rpt_addr_q <= 16'h0;
      refused_q <= 1'b0;
    end else begin
      if (st_q == ST_CHECK && ck_q == CK_TOOL && chk_done) begin
        rpt_code_q <= syn_now; // RULE6
        rpt_addr_q <= chk_res.addr;
      end
      // A new refusal wins over a clear in the same cycle
      if (st_q == ST_HOLD && req_run) begin
        refused_q <= 1'b1; // RULE4
      end else if (req_ref_clr) begin
        refused_q <= 1'b0;
      end
    end
  end

  assign diag_clr = (req_clear && diag_code_q >= CLEARABLE_MIN) // RULE10
    || init_rise || pwr_edit // RULE11 RULE12
    || (diag_set_valid && diag_set_code == CODE_NONE); // RULE13

  // Diagnostic store; a new error wins over any clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      diag_code_q <= CODE_NONE;
      fault_a_q <= 16'h0;
      fault_b_q <= 16'h0;
      diag_halt_q <= 1'b0;
    end else begin
      if (diag_clr) begin
        diag_code_q <= CODE_NONE;
        diag_halt_q <= 1'b0;
      end
      if (diag_set_valid && diag_set_code != CODE_NONE) begin
        diag_code_q <= diag_set_code;
      end
      if (diag_valid) begin
        diag_code_q <= diag.code; // RULE8
        diag_halt_q <= (diag.code < CLEARABLE_MIN)
          || (diag.op_err && cfg_q[CFG_HALT_OP]); // RULE7
        if (diag.op_err) begin
          fault_a_q <= diag.addr[15:0]; // RULE9
          fault_b_q <= diag.addr[31:16];
        end
      end
    end
  end

  // Outputs seen by the execution engine and panel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_led_q <= 1'b0;
      exec_run_q <= 1'b0;
      mem_clear_all_q <= 1'b0;
      mem_clear_volatile_q <= 1'b0;
    end else begin
      err_led_q <= (syn_q != SYN_NONE) || (diag_code_q != CODE_NONE); // RULE1
      exec_run_q <= (st_q == ST_RUN || (st_q == ST_CHECK && ck_q == CK_REWRITE))
        && !diag_halt_q; // RULE3 RULE7
      mem_clear_all_q <= init_rise; // RULE11
      mem_clear_volatile_q <= pwr_edit; // RULE12
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_led_on_error: assert property ( // RULE1
    (syn_q != SYN_NONE) |=> err_led_q)
    else $error("indicator dark with check error pending");

  a_run_starts_check: assert property ( // RULE2
    (st_q == ST_EDIT && run_rise) |=> (st_q == ST_CHECK && chk_start_q && ck_q == CK_RUN))
    else $error("run selection did not start a check");

  a_hold_no_exec: assert property ( // RULE3
    (st_q == ST_HOLD) |=> !exec_run_q)
    else $error("execution while check error pending");

  a_remote_refused: assert property ( // RULE4
    (st_q == ST_HOLD && req_run) |=> (refused_q && st_q != ST_RUN && st_q != ST_CHECK))
    else $error("remote run accepted with check error");

  a_edit_clears: assert property ( // RULE5
    (st_q == ST_HOLD && run_fall) |=> (st_q == ST_EDIT && syn_q == SYN_NONE))
    else $error("edit mode left check error latched");

  a_tool_report: assert property ( // RULE6
    (st_q == ST_CHECK && ck_q == CK_TOOL && chk_done)
      |=> (rpt_addr_q == $past(chk_res.addr) && rpt_code_q == $past(syn_now)
           && st_q == ST_EDIT))
    else $error("tool check report wrong");

  a_diag_store: assert property ( // RULE8
    (diag_valid && diag.code < CLEARABLE_MIN)
      |=> (diag_code_q == $past(diag.code) && diag_halt_q) ##1 err_led_q)
    else $error("low diagnostic code not stored or not halting");

  a_clear_low_kept: assert property ( // RULE10
    (req_clear && diag_code_q < CLEARABLE_MIN && !diag_valid && !diag_set_valid
     && !init_rise && !pwr_edit) |=> $stable(diag_code_q))
    else $error("software clear removed a low code");

  a_rewrite_discard: assert property ( // RULE20
    (st_q == ST_CHECK && ck_q == CK_REWRITE && chk_done && !run_fall
     && (syn_now == SYN_E2 || syn_now == SYN_E5))
      |=> (rewrite_discard_q && !rewrite_commit_q && st_q == ST_RUN))
    else $error("faulty rewrite not discarded");

  a_rewrite_commit: assert property ( // RULE20
    (st_q == ST_CHECK && ck_q == CK_REWRITE && chk_done && !run_fall && syn_now == SYN_NONE)
      |=> (rewrite_commit_q && !rewrite_discard_q && st_q == ST_RUN))
    else $error("clean rewrite not committed");

  a_init_erases: assert property ( // RULE11
    (init_rise && !diag_valid && !diag_set_valid)
      |=> (mem_clear_all_q && diag_code_q == CODE_NONE && syn_q == SYN_NONE))
    else $error("init switch did not clear");
endmodule

// File: sim/ces_checker_model.sv
// Purpose: Program checker stand-in that answers check requests
// Assumes: One request at a time; the bench holds the findings
// Notes: Findings are inverted outside the done pulse
module ces_checker_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic chk_start_q,
  input wire ces_pkg::ces_chk_type res,
  input wire logic [3:0] lat,
  output logic chk_done,
  output ces_pkg::ces_chk_type chk_res
);
  timeunit 1ns;
  timeprecision 1ps;
  import ces_pkg::*;
  logic busy_q;
  logic [3:0] cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
      cnt_q <= 4'h0;
    end else if (chk_start_q) begin
      busy_q <= 1'b1;
      cnt_q <= lat;
    end else if (busy_q && cnt_q == 4'h0) begin
      busy_q <= 1'b0;
    end else if (busy_q) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
  assign chk_done = busy_q && cnt_q == 4'h0;
  assign chk_res = chk_done ? res : ~res;
endmodule

// File: sim/ces_supervisor_tb.sv
// Purpose: Self-checking bench of the error supervisor
// Assumes: Zero-wait APB, pins seen four edges after a change
// Notes: Waits on outputs are bounded; a timeout ends the run
module ces_supervisor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ces_pkg::*;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic mode_run_pin, init_switch_pin, power_restart, diag_valid, diag_set_valid;
  logic [7:0] diag_set_code;
  ces_diag_type diag;
  logic chk_done;
  ces_chk_type chk_res, res;
  logic [3:0] lat;
  logic err_led_q, exec_run_q, diag_halt_q, chk_start_q, rewrite_commit_q;
  logic rewrite_discard_q, mem_clear_all_q, mem_clear_volatile_q;
  logic [6:0] ev;
  int failures = 0;
  int total_checks = 0;
  logic [5:0] t_flag [8] = '{6'h20, 6'h10, 6'h08, 6'h10, 6'h08, 6'h04, 6'h02, 6'h01};
  logic [1:0] t_cfg [8] = '{2'h2, 2'h2, 2'h2, 2'h3, 2'h3, 2'h2, 2'h2, 2'h2};
  logic [2:0] t_code [8] = '{3'h1, 3'h2, 3'h2, 3'h0, 3'h2, 3'h3, 3'h4, 3'h5};

  always #2.5 pclk = ~pclk;
  assign ev = {rewrite_commit_q, chk_done, rewrite_discard_q, mem_clear_all_q, mem_clear_volatile_q,
    exec_run_q, chk_start_q};

  ces_supervisor ces_supervisor_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mode_run_pin(mode_run_pin),
    .init_switch_pin(init_switch_pin), .power_restart(power_restart),
    .diag_valid(diag_valid), .diag(diag), .diag_set_valid(diag_set_valid),
    .diag_set_code(diag_set_code), .chk_done(chk_done), .chk_res(chk_res),
    .err_led_q(err_led_q), .exec_run_q(exec_run_q), .diag_halt_q(diag_halt_q),
    .chk_start_q(chk_start_q), .rewrite_commit_q(rewrite_commit_q),
    .rewrite_discard_q(rewrite_discard_q), .mem_clear_all_q(mem_clear_all_q),
    .mem_clear_volatile_q(mem_clear_volatile_q));
  ces_checker_model ces_checker_model_i (.pclk(pclk), .presetn(presetn),
    .chk_start_q(chk_start_q), .res(res), .lat(lat), .chk_done(chk_done),
    .chk_res(chk_res));

  task automatic conclude;
    if (failures == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
      conclude();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask

  task automatic wait_on(input int i);
    int n;
    n = 0;
    while (ev[i] !== 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 300) begin
      failures++;
      conclude();
    end
  endtask

  task automatic dg(input logic op, input logic [7:0] c, input logic [31:0] a);
    @(posedge pclk);
    diag_valid <= 1'b1;
    diag <= {op, c, a};
    @(posedge pclk);
    diag_valid <= 1'b0;
    diag <= {~op, ~c, ~a};
    repeat (2) @(posedge pclk);
  endtask

  task automatic ds(input logic [7:0] c);
    @(posedge pclk);
    diag_set_valid <= 1'b1;
    diag_set_code <= c;
    @(posedge pclk);
    diag_set_valid <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {mode_run_pin, init_switch_pin, power_restart, diag_valid, diag_set_valid} = '0;
    diag_set_code = 8'h00;
    diag = '0;
    res = '0;
    lat = 4'h1;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdc(OFS_CFG, 32'h3, 32'h2);
    rdc(OFS_STATUS, 32'h7ff, 32'h0);
    apb(1'b0, 8'h1c, 32'h0);
    chk({31'h0, er}, 32'h1);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, OFS_CFG, {30'h0, t_cfg[i]});
      res <= {t_flag[i], 16'h0};
      lat <= i[0] ? 4'h9 : 4'h1;
      mode_run_pin <= 1'b1;
      wait_on(0);
      wait_on(5);
      repeat (3) @(posedge pclk);
      chk({31'h0, exec_run_q}, {31'h0, t_code[i] == 3'h0});
      chk({31'h0, err_led_q}, {31'h0, t_code[i] != 3'h0});
      rdc(OFS_STATUS, 32'h1c, {27'h0, t_code[i], 2'h0});
      if (t_code[i] != 3'h0) begin
        apb(1'b1, OFS_CTRL, 32'h1);
        rdc(OFS_STATUS, 32'h80, 32'h80);
        chk({31'h0, exec_run_q}, 32'h0);
        apb(1'b1, OFS_CTRL, 32'h10);
      end
      mode_run_pin <= 1'b0;
      repeat (8) @(posedge pclk);
      rdc(OFS_STATUS, 32'h3f, 32'h0);
    end
    // Clean and faulty online rewrite, power restart while running
    apb(1'b1, OFS_CFG, 32'h2);
    res <= '0;
    mode_run_pin <= 1'b1;
    wait_on(1);
    apb(1'b1, OFS_CTRL, 32'h8);
    wait_on(6);
    res <= {6'h10, 16'h0};
    apb(1'b1, OFS_CTRL, 32'h8);
    wait_on(4);
    repeat (2) @(posedge pclk);
    chk({31'h0, exec_run_q}, 32'h1);
    power_restart <= 1'b1;
    @(posedge pclk);
    power_restart <= 1'b0;
    @(posedge pclk);
    chk({31'h0, mem_clear_volatile_q}, 32'h0);
    mode_run_pin <= 1'b0;
    repeat (8) @(posedge pclk);
    // Tool check in edit mode
    res <= {6'h02, 16'h1234};
    apb(1'b1, OFS_CTRL, 32'h2);
    wait_on(5);
    repeat (3) @(posedge pclk);
    rdc(OFS_STATUS, 32'h700, 32'h400);
    rdc(OFS_CHK_ADDR, 32'hffff, 32'h1234);
    // Diagnostic errors and their clearing
    dg(1'b1, 8'h2d, 32'hdeadbeef);
    rdc(OFS_CODE, 32'hff, 32'h2d);
    rdc(OFS_FAULT_A, 32'hffff, 32'hbeef);
    rdc(OFS_FAULT_B, 32'hffff, 32'hdead);
    chk({31'h0, diag_halt_q}, 32'h1);
    chk({31'h0, err_led_q}, 32'h1);
    apb(1'b1, OFS_CTRL, 32'h4);
    rdc(OFS_CODE, 32'hff, 32'h0);
    dg(1'b0, 8'h2a, 32'h0);
    chk({31'h0, diag_halt_q}, 32'h1);
    apb(1'b1, OFS_CTRL, 32'h4);
    rdc(OFS_CODE, 32'hff, 32'h2a);
    chk({31'h0, err_led_q}, 32'h1);
    init_switch_pin <= 1'b1;
    wait_on(3);
    init_switch_pin <= 1'b0;
    rdc(OFS_CODE, 32'hff, 32'h0);
    dg(1'b0, 8'h14, 32'h0);
    power_restart <= 1'b1;
    @(posedge pclk);
    power_restart <= 1'b0;
    wait_on(2);
    rdc(OFS_CODE, 32'hff, 32'h0);
    dg(1'b0, 8'h30, 32'h0);
    chk({31'h0, diag_halt_q}, 32'h0);
    ds(8'h50);
    rdc(OFS_CODE, 32'hff, 32'h50);
    chk({31'h0, diag_halt_q}, 32'h0);
    ds(8'h00);
    rdc(OFS_CODE, 32'hff, 32'h0);
    chk({31'h0, err_led_q}, 32'h0);
    conclude();
  end
endmodule
